// ===== src/primary_supervision_scratch_pin_regs.sv
// primary supervision select, scratch and pin level registers
// Functional notes
// [RULE1] Selector bits 3:2: 00 none, 10 clock supervision, 01 and 11 reserved.
// [RULE2] The selector starts a function only on entry to the verification mode.
// [RULE3] Entry to the initial mode clears the selector, readable as zero.
// [RULE4] Response bit 1 is 0 when the previous frame was accepted, 1 when discarded.
// [RULE5] Response bit 0 is odd parity made by the device and not writable.
// [RULE6] Scratch bits 15:2 are written and read back unchanged by the host.
// [RULE7] The scratch value drives no hardware function.
// [RULE8] Bit 8 of the pin register shows the general I/O pin level.
// [RULE9] Bit 7 of the pin register shows the conversion trigger pin level.
// [RULE10] Bit 6 of the pin register shows the second fault output level.
// [RULE11] Bit 5 of the pin register shows the first fault output level.
// [RULE12] Bit 4 of the pin register shows the enable pin level.
// [RULE13] Bit 3 of the pin register shows the stop pin level.
// [RULE14] Bit 2 of the pin register shows the drive command pin level.
// [RULE15] Active clock supervision writes its cycle count to bits 15:8 of the result register; the code keeps the count in the 8-bit result, bits 7:0.
// [RULE16] Parity makes the whole 16-bit response hold an odd number of ones.
// [RULE17] Reserved bits read zero and writes to reserved or read-only bits are ignored.
`timescale 1ns/1ps
`default_nettype none
`include "pri_regs_consts.svh"

module primary_supervision_scratch_pin_regs
    import pri_regs_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // register access from the frame decoder
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic last_frame_invalid,
    output logic [15:0] reg_rdata,
    output logic reg_hit,
    // operating mode
    input wire op_mode_t op_mode,
    // pin levels
    input wire logic general_io_pin,
    input wire logic conversion_trigger_pin,
    input wire logic fault_out_b,
    input wire logic fault_out_a,
    input wire logic enable_pin,
    input wire logic stop_input_pin,
    input wire logic drive_input_pin,
    // clock supervision handoff
    input wire logic [7:0] clock_check_count,
    input wire logic clock_check_done,
    output logic clock_check_start,
    output logic [7:0] clock_check_result,
    output logic [1:0] verify_function_select
);

    // =========================================================
    // state
    // =========================================================
    verify_function_t vfs, next_vfs;
    logic [13:0] scratch_value, next_scratch_value;
    op_mode_t mode_prev, next_mode_prev;
    logic start, next_start;
    logic [7:0] result, next_result;
    logic [15:0] rdata, next_rdata;
    logic hit, next_hit;
    logic [15:0] raw_word;
    logic [15:0] parity_word;
    logic [8:2] pin_levels;
    logic enter_verify;
    logic enter_initial;

    // =========================================================
    // pin snapshot and mode edges
    // =========================================================
    always_comb
    begin
        pin_levels[`GPIO_LEVEL_BIT] = general_io_pin; // [RULE8]
        pin_levels[`CONV_TRIG_LEVEL_BIT] = conversion_trigger_pin; // [RULE9]
        pin_levels[`FAULT_B_LEVEL_BIT] = fault_out_b; // [RULE10]
        pin_levels[`FAULT_A_LEVEL_BIT] = fault_out_a; // [RULE11]
        pin_levels[`ENABLE_LEVEL_BIT] = enable_pin; // [RULE12]
        pin_levels[`STOP_LEVEL_BIT] = stop_input_pin; // [RULE13]
        pin_levels[`DRIVE_LEVEL_BIT] = drive_input_pin; // [RULE14]
        enter_verify = (op_mode == mode_verification) && (mode_prev != mode_verification);
        enter_initial = (op_mode == mode_initial) && (mode_prev != mode_initial);
    end

    // =========================================================
    // selector, mode history and start pulse
    // =========================================================
    always_comb
    begin
        next_vfs = vfs;
        next_mode_prev = op_mode;
        next_start = 1'b0;
        if (reg_wr && reg_addr == `SUPERVISION_SELECT_CONTROL_ADDR)
        begin
            // write only stores; no function starts here
            next_vfs = verify_function_t'(reg_wdata[`VFS_MSB:`VFS_LSB]); // [RULE2] [RULE17]
        end
        if (enter_verify && vfs == vfs_clock_supervision)
        begin
            next_start = 1'b1; // [RULE1] [RULE2]
        end
        if (enter_initial)
        begin
            // hardware clear wins over a same-cycle write
            next_vfs = vfs_none; // [RULE3]
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            vfs <= vfs_none;
            // history starts in initial mode, so release is no entry
            mode_prev <= mode_initial;
            start <= 1'b0;
        end
        else
        begin
            vfs <= next_vfs;
            mode_prev <= next_mode_prev;
            start <= next_start;
        end
    end

    // =========================================================
    // scratch word
    // =========================================================
    always_comb
    begin
        next_scratch_value = scratch_value;
        if (reg_wr && reg_addr == `LINK_INTEGRITY_SCRATCH_ADDR)
        begin
            // storage only, feeds nothing but readback
            next_scratch_value = reg_wdata[`SCRATCH_MSB:`SCRATCH_LSB]; // [RULE6] [RULE7]
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scratch_value <= 14'h0000;
        end
        else
        begin
            scratch_value <= next_scratch_value;
        end
    end

    // =========================================================
    // supervision result
    // =========================================================
    always_comb
    begin
        next_result = result;
        if (clock_check_done)
        begin
            next_result = clock_check_count; // [RULE15]
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            result <= 8'h00;
        end
        else
        begin
            result <= next_result;
        end
    end

    // =========================================================
    // read data
    // =========================================================
    always_comb
    begin
        raw_word = 16'h0000; // [RULE17]
        next_hit = 1'b0;
        case (reg_addr)
            `SUPERVISION_SELECT_CONTROL_ADDR:
            begin
                raw_word[`VFS_MSB:`VFS_LSB] = vfs;
                next_hit = 1'b1;
            end
            `LINK_INTEGRITY_SCRATCH_ADDR:
            begin
                raw_word[`SCRATCH_MSB:`SCRATCH_LSB] = scratch_value; // [RULE6]
                next_hit = 1'b1;
            end
            `PRIMARY_PIN_LEVELS_ADDR:
            begin
                raw_word[8:2] = pin_levels;
                next_hit = 1'b1;
            end
            default:
            begin
                raw_word = 16'h0000;
            end
        endcase
        raw_word[`LFI_BIT] = last_frame_invalid; // [RULE4]
        next_hit = next_hit & reg_rd;
    end

    odd_parity_word parity_gen
    (
        .data_in(raw_word),
        .word_out(parity_word) // [RULE5] [RULE16]
    );

    always_comb
    begin
        next_rdata = reg_rd ? parity_word : rdata;
    end

    // =========================================================
    // read word registers
    // =========================================================
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            // reset word carries the parity bit only
            rdata <= 16'h0001;
            hit <= 1'b0;
        end
        else
        begin
            rdata <= next_rdata;
            hit <= next_hit;
        end
    end

    always_comb
    begin
        reg_rdata = rdata;
        reg_hit = hit;
        clock_check_start = start;
        clock_check_result = result;
        verify_function_select = vfs;
    end

endmodule

`default_nettype wire

// ===== src/pri_regs_consts.svh
// offsets, field positions, reset values for the primary supervision/scratch/pin registers
`ifndef PRI_REGS_CONSTS_SVH
`define PRI_REGS_CONSTS_SVH

// register offsets
`define SUPERVISION_SELECT_CONTROL_ADDR 7'h08
`define LINK_INTEGRITY_SCRATCH_ADDR 7'h09
`define PRIMARY_PIN_LEVELS_ADDR 7'h0A

// reset values
`define SUPERVISION_SELECT_CONTROL_RST 16'h0001
`define LINK_INTEGRITY_SCRATCH_RST 16'h0001

// field positions
`define VFS_MSB 3
`define VFS_LSB 2
`define SCRATCH_MSB 15
`define SCRATCH_LSB 2
`define GPIO_LEVEL_BIT 8
`define CONV_TRIG_LEVEL_BIT 7
`define FAULT_B_LEVEL_BIT 6
`define FAULT_A_LEVEL_BIT 5
`define ENABLE_LEVEL_BIT 4
`define STOP_LEVEL_BIT 3
`define DRIVE_LEVEL_BIT 2
`define LFI_BIT 1
`define PARITY_BIT 0

`endif

// ===== src/pri_regs_pkg.sv
// types for the primary supervision/scratch/pin register bank
package pri_regs_pkg;

    typedef enum logic [1:0] {
        vfs_none = 2'b00,
        vfs_res1 = 2'b01,
        vfs_clock_supervision = 2'b10,
        vfs_res3 = 2'b11
    } verify_function_t;

    typedef enum logic [2:0] {
        mode_initial = 3'b001,
        mode_other = 3'b010,
        mode_verification = 3'b101
    } op_mode_t;

endpackage

// ===== src/odd_parity_word.sv
// fills bit 0 of a response word so the whole word carries odd parity
`timescale 1ns/1ps
`default_nettype none

module odd_parity_word
(
    // data with bit 0 ignored
    input wire logic [15:0] data_in,
    // completed word
    output logic [15:0] word_out
);

    always_comb
    begin
        word_out = {data_in[15:1], ~(^data_in[15:1])};
    end

endmodule

`default_nettype wire

// ===== test/pri_regs_checker.sv
// assertions on the primary register bank ports
`timescale 1ns/1ps
`default_nettype none
module pri_regs_checker
    import pri_regs_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // register access
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic last_frame_invalid,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_hit,
    // operating mode
    input wire op_mode_t op_mode,
    // pin levels
    input wire logic general_io_pin,
    input wire logic conversion_trigger_pin,
    input wire logic fault_out_b,
    input wire logic fault_out_a,
    input wire logic enable_pin,
    input wire logic stop_input_pin,
    input wire logic drive_input_pin,
    // clock supervision handoff
    input wire logic [7:0] clock_check_count,
    input wire logic clock_check_done,
    input wire logic clock_check_start,
    input wire logic [7:0] clock_check_result,
    input wire logic [1:0] verify_function_select
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    wire logic [6:0] pins = {general_io_pin, conversion_trigger_pin, fault_out_b,
        fault_out_a, enable_pin, stop_input_pin, drive_input_pin};
    wire logic mapped = reg_addr inside {7'h08, 7'h09, 7'h0A};
    a_parity_odd: assert property (^reg_rdata) else $error("parity");
    a_flag_copy:
        assert property (reg_rd |=> reg_rdata[1] == $past(last_frame_invalid))
        else $error("flag");
    a_pin_levels:
        assert property (reg_rd && reg_addr == 7'h0A |=> reg_rdata[15:2] == {7'h00, $past(pins)})
        else $error("pins");
    a_scratch_back:
        assert property (reg_wr && reg_addr == 7'h09 ##2 reg_rd && reg_addr == 7'h09
            |=> reg_rdata[15:2] == $past(reg_wdata[15:2], 3)) else $error("scratch");
    a_init_clear:
        assert property ($changed(op_mode) && op_mode == mode_initial
            |=> verify_function_select == 2'b00) else $error("clear");
    a_start_entry:
        assert property (clock_check_start == ($past(op_mode) == mode_verification &&
            $past(op_mode, 2) != mode_verification && $past(verify_function_select) == 2'b10))
        else $error("start");
    a_result_latch:
        assert property (clock_check_done |=> clock_check_result == $past(clock_check_count))
        else $error("result");
    a_unmapped_read:
        assert property (reg_rd && !mapped |=> !reg_hit && reg_rdata[15:2] == 14'h0000)
        else $error("unmapped");
    a_mapped_hit:
        assert property (reg_rd && mapped |=> reg_hit)
        else $error("hit");
    a_select_read:
        assert property (reg_rd && reg_addr == 7'h08
            |=> reg_rdata[15:2] == {12'h000, $past(verify_function_select)})
        else $error("select");
    c_start: cover property (clock_check_start);
    c_scratch: cover property (reg_wr && reg_addr == 7'h09 ##2 reg_rd && reg_addr == 7'h09);
    c_flag: cover property (reg_hit && reg_rdata[1]);
    c_done: cover property (clock_check_done);
endmodule
bind primary_supervision_scratch_pin_regs pri_regs_checker u_chk (.*);
`default_nettype wire

// ===== test/host_frame_model.sv
// host model issuing register frames to the bank
`timescale 1ns/1ps
`default_nettype none
module host_frame_model
(
    input wire logic clock,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_hit,
    output logic reg_wr = 1'b0,
    output logic reg_rd = 1'b0,
    output logic [6:0] reg_addr = 7'h00,
    output logic [15:0] reg_wdata = 16'h0000
);
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [6:0] a, output logic [15:0] d, output logic h);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
        h = reg_hit;
    endtask
endmodule
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the primary register bank
`timescale 1ns/1ps
`default_nettype none
module testbench import pri_regs_pkg::*;;
    logic clock = 1'b0, rst_b = 1'b0, lfi = 1'b0, done = 1'b0, hit, start, hb;
    logic [6:0] pins = 7'h00;
    wire logic wr, rd;
    wire logic [6:0] addr;
    wire logic [15:0] wdata;
    logic [15:0] rdata, got;
    logic [7:0] cnt = 8'h00, result;
    logic [1:0] sel;
    op_mode_t mode = mode_initial;
    int errors = 0, num_checks = 0, starts = 0;
    typedef struct {logic [6:0] a; logic [15:0] w; logic l; logic [15:0] v; logic h;} row_t;
    row_t rows [8] = '{'{7'h08, 16'hFFFF, 0, 16'h000C, 1}, '{7'h08, 16'h0004, 1, 16'h0004, 1},
        '{7'h08, 16'h0008, 0, 16'h0008, 1}, '{7'h09, 16'hABCC, 0, 16'hABCC, 1},
        '{7'h09, 16'hFFFF, 1, 16'hFFFC, 1}, '{7'h09, 16'h0003, 0, 16'h0000, 1},
        '{7'h0A, 16'hFFFF, 1, 16'h0000, 1}, '{7'h0B, 16'hFFFF, 0, 16'h0000, 0}};
    host_frame_model host (.clock(clock), .reg_rdata(rdata), .reg_hit(hit), .reg_wr(wr),
        .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata));
    primary_supervision_scratch_pin_regs uut (.clock(clock), .rst_b(rst_b), .reg_wr(wr),
        .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata), .last_frame_invalid(lfi),
        .reg_rdata(rdata), .reg_hit(hit), .op_mode(mode), .general_io_pin(pins[6]),
        .conversion_trigger_pin(pins[5]), .fault_out_b(pins[4]), .fault_out_a(pins[3]),
        .enable_pin(pins[2]), .stop_input_pin(pins[1]), .drive_input_pin(pins[0]),
        .clock_check_count(cnt), .clock_check_done(done), .clock_check_start(start),
        .clock_check_result(result), .verify_function_select(sel));
    initial forever #2.5 clock = ~clock;
    always @(posedge clock) if (start === 1'b1) starts <= starts + 1;
    task automatic chk(input string n, input logic [15:0] s, e);
        num_checks++;
        if (s !== e)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rdchk(input logic [6:0] a, input logic [15:0] v, input logic h);
        host.rd(a, got, hb);
        chk("word", got, {v[15:2], lfi, ~^{v[15:2], lfi}});
        chk("hit", {15'h0, hb}, {15'h0, h});
    endtask
    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (6) @(posedge clock);
        chk("reset word", rdata, 16'h0001);
        chk("reset select", {14'h0, sel}, 16'h0000);
        chk("reset result", {8'h00, result}, 16'h0000);
        chk("reset hit", {15'h0, hit}, 16'h0000);
        rst_b <= 1'b1;
    endtask
    task automatic end_sim();
        if (errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        do_reset();
        mode <= mode_other;
        foreach (rows[i])
        begin
            @(posedge clock) lfi <= rows[i].l;
            host.wr(rows[i].a, rows[i].w);
            rdchk(rows[i].a, rows[i].v, rows[i].h);
        end
        chk("select", {14'h0, sel}, 16'h0002);
        chk("no start", starts[15:0], 16'h0000);
        for (int i = 0; i < 7; i++)
        begin
            @(posedge clock) pins <= 7'h01 << i;
            rdchk(7'h0A, {7'h00, 7'h01 << i, 2'b00}, 1);
        end
        @(posedge clock) pins <= 7'h7F;
        rdchk(7'h0A, 16'h01FC, 1);
        for (int c = 0; c < 4; c++)
        begin
            host.wr(7'h08, {12'h000, c[1:0], 2'b00});
            @(posedge clock) mode <= mode_verification;
            repeat (4) @(posedge clock);
            chk("starts", starts[15:0], {15'h0, c >= 2});
            mode <= mode_initial;
            rdchk(7'h08, 16'h0000, 1);
            @(posedge clock) mode <= mode_other;
        end
        @(posedge clock) mode <= mode_verification;
        host.wr(7'h08, 16'h0008);
        repeat (3) @(posedge clock);
        chk("late select", {14'h0, sel}, 16'h0002);
        chk("late start", starts[15:0], 16'h0001);
        mode <= mode_initial;
        @(posedge clock) cnt <= 8'hA5;
        done <= 1'b1;
        @(posedge clock) done <= 1'b0;
        cnt <= 8'h3C;
        @(posedge clock) chk("result", {8'h00, result}, 16'h00A5);
        lfi <= 1'b0;
        do_reset();
        rdchk(7'h08, 16'h0000, 1);
        rdchk(7'h09, 16'h0000, 1);
        end_sim();
    end
    initial
    begin
        #20000;
        errors++;
        end_sim();
    end
endmodule
`default_nettype wire
